// [dv/rwpg_props.sv]
// Purpose: Assertions for the register write protect gate
// Assumes: Zero wait states; write data lands at the data phase edge
// Notes:   Bound to rwpg_top
`default_nettype none
module rwpg_props #(parameter int REG_W = 16) (
  input wire logic             clk, rst_n, hsel, hwrite, hready,
  input wire logic [31:0]      haddr, hwdata, hrdata,
  input wire logic [1:0]       htrans,
  input wire logic [2:0]       hsize,
  input wire logic [REG_W-1:0] clk_reg_q, lp_reg_q, vd_reg_q,
  input wire logic             clock_regs_write_enable, lowpower_regs_write_enable,
  input wire logic             voltage_detect_regs_write_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire       aw = hsel && hready && htrans[1] && hwrite;
  wire [7:0] a  = haddr[7:0];
  wire [2:0] en = {voltage_detect_regs_write_enable, lowpower_regs_write_enable,
                   clock_regs_write_enable};
  sequence key_wr;
    aw && a == 8'h00 && hsize == 3'b001 ##1 hwdata[15:8] == 8'hA5;
  endsequence
  sequence prot_wr(logic [7:0] o, logic e);
    aw && a == o ##1 e;
  endsequence
  ctrl_unlock_a: assert property (
    key_wr |=> en == {$past(hwdata[3]), $past(hwdata[1:0])}) else $error("enables not taken");
  ctrl_locked_a: assert property (
    $changed(en) |-> $past(aw && a == 8'h00 && hsize == 3'b001, 2) &&
    $past(hwdata[15:8]) == 8'hA5) else $error("enables changed without key");
  clk_land_a: assert property (
    prot_wr(8'h10, clock_regs_write_enable) |=> clk_reg_q == $past(hwdata[REG_W-1:0]))
    else $error("clock register write lost");
  clk_gate_a: assert property (
    $changed(clk_reg_q) |-> $past(clock_regs_write_enable) && $past(aw && a == 8'h10, 2))
    else $error("clock register changed while locked");
  lp_gate_a: assert property (
    $changed(lp_reg_q) |-> $past(lowpower_regs_write_enable) && $past(aw && a == 8'h14, 2))
    else $error("low-power register changed while locked");
  vd_gate_a: assert property (
    $changed(vd_reg_q) |-> $past(voltage_detect_regs_write_enable) && $past(aw && a == 8'h18, 2))
    else $error("voltage register changed while locked");
  rsvd_zero_a: assert property (
    hsel && hready && htrans[1] && !hwrite && a == 8'h00 |=> hrdata[7:4] == 4'h0 && !hrdata[2])
    else $error("unused control bits not zero");
endmodule : rwpg_props
bind rwpg_top rwpg_props #(.REG_W(REG_W)) u_props (.*);
`default_nettype wire

// [dv/rwpg_tb_top.sv]
// Purpose: Self-checking bench for the register write protect gate
// Assumes: Zero-wait slave, hready tied to hreadyout
// Notes:   Random data from an LFSR; reads checked through a queue
`default_nettype none
module rwpg_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, dp = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, s = 32'h9eca_de6a;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010, sz, st_m = 3'b000;
  logic [15:0] cq, lq, vq, m [3];
  logic [7:0]  en_m = 8'h00, ky;
  logic        hreadyout, hresp, e_c, e_l, e_v, dv = 0;
  logic [63:0] e, expq [$];
  int          fail_count = 0, n_checks = 0, cyc = 0;
  rwpg_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .clk_reg_q(cq), .lp_reg_q(lq), .vd_reg_q(vq),
    .clock_regs_write_enable(e_c), .lowpower_regs_write_enable(e_l),
    .voltage_detect_regs_write_enable(e_v));
  initial forever #4 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction : lfsr
  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask : cmp
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // Address phase held until ready, then data phase until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [2:0] z,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= z;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] k, input logic [31:0] x);
    expq.push_back({k, x});
    xfer(1'b0, a, 3'b010, 32'h0000_0000);
  endtask : rd
  always @(posedge clk)
  begin
    if (dv && hreadyout)
      cmp("hresp", 32'h0000_0000, 32'(hresp));
    if (dp && hreadyout && expq.size() > 0)
    begin
      e = expq.pop_front();
      cmp("hrdata", e[31:0], hrdata & e[63:32]);
    end
    dp = hsel && htrans[1] && !hwrite && hreadyout;
    dv = hsel && htrans[1] && hreadyout;
    cyc++;
    if (cyc > 2000)
    begin
      fail_count++;
      complete_run();
    end
  end
  initial
  begin
    m = '{16'h0000, 16'h0000, 16'h0000};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 24; k++)
    begin
      if (k == 12)
      begin
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        en_m = 8'h00;
        st_m = 3'b000;
        m = '{16'h0000, 16'h0000, 16'h0000};
      end
      for (int i = 0; i < 3; i++)
      begin
        s = lfsr(s);
        xfer(1'b1, 8'h10 + 8'(4 * i), 3'b010, s);
        if (en_m[i == 2 ? 3 : i])
          m[i] = s[15:0];
        else
          st_m[i] = 1'b1;
      end
      s = lfsr(s);
      ky = (k % 3 == 2) ? s[15:8] : 8'hA5;
      sz = (k % 4 == 3) ? 3'b010 : 3'b001;
      xfer(1'b1, 8'h00, sz, {16'h0000, ky, s[7:0]});
      if (ky == 8'hA5 && sz == 3'b001)
        en_m = s[7:0] & 8'h0b;
      rd(8'h00, 32'h0000_00ff, {24'h00_0000, en_m});
      rd(8'h04, 32'h0000_0007, {29'h000_0000, st_m});
      if (k % 2 == 1)
      begin
        xfer(1'b1, 8'h04, 3'b010, 32'h0000_0007);
        st_m = 3'b000;
      end
      for (int i = 0; i < 3; i++)
        rd(8'h10 + 8'(4 * i), 32'h0000_ffff, {16'h0000, m[i]});
      @(negedge clk);
      cmp("enables", {29'h0, en_m[3], en_m[1:0]}, {29'h0, e_v, e_l, e_c});
      cmp("clk_reg_q", {16'h0000, m[0]}, {16'h0000, cq});
      cmp("lp_reg_q", {16'h0000, m[1]}, {16'h0000, lq});
      cmp("vd_reg_q", {16'h0000, m[2]}, {16'h0000, vq});
      @(posedge clk);
    end
    rd(8'h40, 32'hffff_ffff, 32'h0000_0000);
    repeat (2) @(posedge clk);
    cmp("pending", 32'h0000_0000, 32'(expq.size()));
    complete_run();
  end
endmodule : rwpg_tb_top
`default_nettype wire

// [src/rwpg_consts.svh]
// Purpose: Constants for the register write protect gate
// Assumes: AHB-Lite byte addresses, one 32-bit word per register
// Notes:   Offsets, fields, key and reset values
`ifndef RWPG_CONSTS_SVH
`define RWPG_CONSTS_SVH

`define RWPG_ADDR_W          8
`define RWPG_OFF_CTRL        8'h00
`define RWPG_OFF_STATUS      8'h04
`define RWPG_OFF_CLK_REG     8'h10
`define RWPG_OFF_LP_REG      8'h14
`define RWPG_OFF_VD_REG      8'h18
`define RWPG_KEY             8'hA5
`define RWPG_KEY_MSB         15
`define RWPG_KEY_LSB         8
`define RWPG_BIT_CLK         0
`define RWPG_BIT_LP          1
`define RWPG_BIT_VD          3
`define RWPG_EN_MASK         8'h0B
`define RWPG_CTRL_RST        8'h00
`define RWPG_PROT_RST        16'h0000
`define RWPG_HSIZE_HALF      3'b001
`define RWPG_HSIZE_WORD      3'b010

`endif

// [src/rwpg_pkg.sv]
// Purpose: Types for the register write protect gate
// Assumes: Constants come from rwpg_consts.svh
// Notes:   Protected group selector
`default_nettype none
package rwpg_pkg;
  typedef enum logic [1:0] {
    RWPG_GRP_CLK  = 2'b00,
    RWPG_GRP_LP   = 2'b01,
    RWPG_GRP_VD   = 2'b11,
    RWPG_GRP_NONE = 2'b10
  } rwpg_grp_t;
endpackage : rwpg_pkg
`default_nettype wire

// [src/rwpg_prot_reg.sv]
// Purpose: One protected register with a write gate
// Assumes: Write strobe already decoded by the bus slave
// Notes:   Write lands only while the group enable is set
`default_nettype none
`include "rwpg_consts.svh"
module rwpg_prot_reg #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         wr,
  input  wire logic         allow,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] q,
  output logic              blocked
);
  logic [W-1:0] q_ff;
  logic         blk_ff;
  wire          take = wr & allow;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q_ff   <= W'(`RWPG_PROT_RST);
      blk_ff <= 1'b0;
    end
    else
    begin
      if (take)
        q_ff <= wdata;
      blk_ff <= wr & ~allow;
    end
  end

  assign q       = q_ff;
  assign blocked = blk_ff;
endmodule : rwpg_prot_reg
`default_nettype wire

// [src/rwpg_top.sv]
// Purpose: Write protect control register and its three gated register groups
// Assumes: Single AHB-Lite master, single word or halfword transfers
// Notes:   Zero wait states, OKAY always, unmapped reads return zero
//          Reads forward the result of a write still in its data phase
`default_nettype none
`include "rwpg_consts.svh"

// Functional notes
// - Writes to critical registers are blocked while their protection is active.
// - Control writes take effect only as 16-bit access with A5h upper byte.
// - Bit 0 gates writes to the clock generation registers.
// - Bit 1 gates writes to the low-power mode registers.
// - Bit 3 gates writes to the voltage detection registers.
module rwpg_top #(
  parameter int REG_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [REG_W-1:0]  clk_reg_q,
  output logic      [REG_W-1:0]  lp_reg_q,
  output logic      [REG_W-1:0]  vd_reg_q,
  output logic                   clock_regs_write_enable,
  output logic                   lowpower_regs_write_enable,
  output logic                   voltage_detect_regs_write_enable
);

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  logic [`RWPG_ADDR_W-1:0] addr_ff;
  logic                    wr_ff;
  logic                    rd_ff;
  logic [2:0]              size_ff;
  logic [7:0]              ctrl_ff;
  logic [31:0]             rdata_ff;
  logic [2:0]              blk_ff;
  logic [2:0]              blk_now;

  // Address, direction and size are held for the data phase, when hwdata arrives
  wire act = hsel & hready & htrans[1];
  wire [`RWPG_ADDR_W-1:0] a_in = haddr[`RWPG_ADDR_W-1:0];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      addr_ff <= '0;
      wr_ff   <= 1'b0;
      rd_ff   <= 1'b0;
      size_ff <= 3'b000;
    end
    else
    begin
      addr_ff <= a_in;
      wr_ff   <= act & hwrite;
      rd_ff   <= act & ~hwrite;
      size_ff <= hsize;
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [`RWPG_ADDR_W-1:0] a,
                               input logic [`RWPG_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // Key and new enables share one halfword; word or byte stores are dropped
  wire key_ok   = (hwdata[`RWPG_KEY_MSB:`RWPG_KEY_LSB] == `RWPG_KEY);
  wire size_ok  = (size_ff == `RWPG_HSIZE_HALF);
  wire ctrl_wr  = wr_ff & hit(addr_ff, `RWPG_OFF_CTRL) & size_ok & key_ok;
  wire [7:0] nxt_ctrl = hwdata[7:0] & `RWPG_EN_MASK;

  // ----------------------------------------------------------------
  // Protected group decode
  // ----------------------------------------------------------------
  // Only these three offsets belong to a protected group
  function automatic rwpg_pkg::rwpg_grp_t grp_of(input logic [`RWPG_ADDR_W-1:0] a);
    unique case (a)
      `RWPG_OFF_CLK_REG: grp_of = rwpg_pkg::RWPG_GRP_CLK;
      `RWPG_OFF_LP_REG:  grp_of = rwpg_pkg::RWPG_GRP_LP;
      `RWPG_OFF_VD_REG:  grp_of = rwpg_pkg::RWPG_GRP_VD;
      default:           grp_of = rwpg_pkg::RWPG_GRP_NONE;
    endcase
  endfunction : grp_of

  rwpg_pkg::rwpg_grp_t wr_grp;
  assign wr_grp = grp_of(addr_ff);

  wire clk_wr = wr_ff & (wr_grp == rwpg_pkg::RWPG_GRP_CLK);
  wire lp_wr  = wr_ff & (wr_grp == rwpg_pkg::RWPG_GRP_LP);
  wire vd_wr  = wr_ff & (wr_grp == rwpg_pkg::RWPG_GRP_VD);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_ff <= `RWPG_CTRL_RST;
    else if (ctrl_wr)
      ctrl_ff <= nxt_ctrl;
  end

  // Enables come straight from the control flops, one edge after the key write
  assign clock_regs_write_enable          = ctrl_ff[`RWPG_BIT_CLK];
  assign lowpower_regs_write_enable       = ctrl_ff[`RWPG_BIT_LP];
  assign voltage_detect_regs_write_enable = ctrl_ff[`RWPG_BIT_VD];

  // ----------------------------------------------------------------
  // Protected groups
  // ----------------------------------------------------------------
  // Each group is gated by its enable as it stood before this write
  rwpg_prot_reg #(.W(REG_W)) u_clk (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr      (clk_wr),
    .allow   (clock_regs_write_enable),
    .wdata   (hwdata[REG_W-1:0]),
    .q       (clk_reg_q),
    .blocked (blk_now[0])
  );

  rwpg_prot_reg #(.W(REG_W)) u_lp (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr      (lp_wr),
    .allow   (lowpower_regs_write_enable),
    .wdata   (hwdata[REG_W-1:0]),
    .q       (lp_reg_q),
    .blocked (blk_now[1])
  );

  rwpg_prot_reg #(.W(REG_W)) u_vd (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr      (vd_wr),
    .allow   (voltage_detect_regs_write_enable),
    .wdata   (hwdata[REG_W-1:0]),
    .q       (vd_reg_q),
    .blocked (blk_now[2])
  );

  // ----------------------------------------------------------------
  // Sticky blocked-write status, cleared by writing ones
  // ----------------------------------------------------------------
  // blk_now lags the refused write by one edge; an attempt that meets a
  // clear in the same cycle survives it
  wire       st_wr   = wr_ff & hit(addr_ff, `RWPG_OFF_STATUS);
  wire [2:0] st_clr  = st_wr ? hwdata[2:0] : 3'b000;
  wire [2:0] nxt_blk = (blk_ff & ~st_clr) | blk_now;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      blk_ff <= 3'b000;
    else
      blk_ff <= nxt_blk;
  end

  // ----------------------------------------------------------------
  // Read-after-write forwarding
  // ----------------------------------------------------------------
  // A read whose address phase meets a write's data phase must return
  // what that write leaves behind, so the read mux looks one edge ahead
  function automatic logic [REG_W-1:0] fwd(input logic             we,
                                           input logic [REG_W-1:0] nv,
                                           input logic [REG_W-1:0] ov);
    fwd = we ? nv : ov;
  endfunction : fwd

  // Refused writes of the current data phase, not yet in blk_now
  wire [2:0]       blk_evt   = {vd_wr & ~voltage_detect_regs_write_enable,
                                lp_wr & ~lowpower_regs_write_enable,
                                clk_wr & ~clock_regs_write_enable};
  wire [7:0]       ctrl_view = ctrl_wr ? nxt_ctrl : ctrl_ff;
  wire [2:0]       st_view   = nxt_blk | blk_evt;

  wire [REG_W-1:0] clk_view  = fwd(clk_wr & clock_regs_write_enable,
                                   hwdata[REG_W-1:0], clk_reg_q);
  wire [REG_W-1:0] lp_view   = fwd(lp_wr & lowpower_regs_write_enable,
                                   hwdata[REG_W-1:0], lp_reg_q);
  wire [REG_W-1:0] vd_view   = fwd(vd_wr & voltage_detect_regs_write_enable,
                                   hwdata[REG_W-1:0], vd_reg_q);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data is captured at the address-phase edge, so the slave
  // never needs a wait state
  wire rd_addr = act & ~hwrite;
  wire [31:0] rd_mux =
      hit(a_in, `RWPG_OFF_CTRL)    ? {24'h00_0000, ctrl_view} :
      hit(a_in, `RWPG_OFF_STATUS)  ? {29'h000_0000, st_view} :
      hit(a_in, `RWPG_OFF_CLK_REG) ? 32'(clk_view) :
      hit(a_in, `RWPG_OFF_LP_REG)  ? 32'(lp_view) :
      hit(a_in, `RWPG_OFF_VD_REG)  ? 32'(vd_view) :
      32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_ff <= 32'h0000_0000;
    else if (rd_addr)
      rdata_ff <= rd_mux;
  end

  assign hrdata    = rdata_ff;
  // No wait states and no error response
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : rwpg_top
`default_nettype wire
